/* hdl/comparator_control_regs.sv */
// Comparator control and status registers behind a Wishbone slave.
`timescale 1ns/1ps

module comparator_control_regs #(
  parameter int FILTER_DEPTH = cmp_ctrl_pkg::FILTER_LEN
) (
  input  wire logic                            ref_clk_in,
  input  wire logic                            reset_n_in,
  input  wire logic                            wb_cyc_in,
  input  wire logic                            wb_stb_in,
  input  wire logic                            wb_we_in,
  input  wire logic [cmp_ctrl_pkg::ADDR_W-1:0] wb_adr_in,
  input  wire logic [cmp_ctrl_pkg::SEL_W-1:0]  wb_sel_in,
  input  wire logic [cmp_ctrl_pkg::DATA_W-1:0] wb_dat_in,
  output logic      [cmp_ctrl_pkg::DATA_W-1:0] wb_dat_out,
  output logic                                 wb_ack_out,
  input  wire logic                            cmp_raw_in,
  output cmp_ctrl_pkg::analog_ctrl_t           analog_ctrl_out,
  output logic                                 cmp_irq_out,
  output logic                                 irq_out
);
  import cmp_ctrl_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0]             ctl_one_r;
  logic [7:0]             ctl_two_r;
  logic [7:0]             buf_dis_r;
  logic [EVT_W-1:0]       evt_status_r;
  logic [EVT_W-1:0]       evt_mask_r;
  logic                   ack_r;
  logic [DATA_W-1:0]      rdata_r;
  logic [FILTER_DEPTH-1:0] filt_hist_r;
  logic                   filt_out_r;
  logic                   result_prev_r;
  logic                   cmp_result;
  logic                   rise_evt;
  logic                   fall_evt;
  logic                   flag_set_evt;
  logic                   req;
  logic                   wr_stb;
  logic [7:0]             wr_byte;
  logic [ADDR_W-3:0]      idx;
  logic [7:0]             rd_byte;
  logic                   take;
  logic                   rd_take;
  logic                   wr_ctl_one;
  logic                   wr_ctl_two;
  logic                   wr_buf_dis;
  logic                   wr_evt_status;
  logic                   wr_evt_mask;
  logic [7:0]             ctl_one_nxt;
  logic [7:0]             ctl_two_nxt;
  logic [7:0]             buf_dis_nxt;
  logic [EVT_W-1:0]       evt_now;
  logic [EVT_W-1:0]       evt_status_nxt;
  logic [EVT_W-1:0]       evt_mask_nxt;
  logic                   cmp_irq_r;
  logic                   irq_r;
  analog_ctrl_t           analog_ctrl_r;
  logic                   cmp_power_on;
  logic                   result_filter_sel;
  logic                   cmp_edge_select;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-3:0] a,
                               input logic [7:0]        reg_idx);
    hit = (a == (ADDR_W-2)'(reg_idx));
  endfunction : hit

  assign req     = wb_cyc_in & wb_stb_in;
  assign idx     = wb_adr_in[ADDR_W-1:2];
  assign wr_byte = wb_dat_in[7:0];
  assign take    = req & ~ack_r;
  assign rd_take = take & ~wb_we_in;
  // Writes take effect on the edge that raises ack, low lane only.
  assign wr_stb  = take & wb_we_in & wb_sel_in[0];

  // ----------------------------------------------------------------------
  // Per-register write strobes
  // ----------------------------------------------------------------------
  assign wr_ctl_one    = wr_stb & hit(idx, IDX_CTL_ONE);
  assign wr_ctl_two    = wr_stb & hit(idx, IDX_CTL_TWO);
  assign wr_buf_dis    = wr_stb & hit(idx, IDX_BUF_DIS);
  assign wr_evt_status = wr_stb & hit(idx, IDX_EVT_STATUS);
  assign wr_evt_mask   = wr_stb & hit(idx, IDX_EVT_MASK);

  // ----------------------------------------------------------------------
  // Live control fields
  // ----------------------------------------------------------------------
  assign cmp_power_on      = ctl_one_r[CTL1_POWER_ON];
  assign cmp_edge_select   = ctl_one_r[CTL1_EDGE_SEL];
  assign result_filter_sel = ctl_two_r[CTL2_FILTER];

  // ----------------------------------------------------------------------
  // Comparator result path
  // ----------------------------------------------------------------------
  // Power gating of input
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      filt_hist_r <= '0;
    end else begin
      filt_hist_r <= {filt_hist_r[FILTER_DEPTH-2:0],
                      cmp_raw_in & cmp_power_on};
    end
  end

  // The filter follows only once all recent samples agree.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      filt_out_r <= 1'b0;
    end else if (&filt_hist_r) begin
      filt_out_r <= 1'b1;
    end else if (~|filt_hist_r) begin
      filt_out_r <= 1'b0;
    end
  end

  assign cmp_result = result_filter_sel ? filt_out_r : filt_hist_r[0];

  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_prev_r <= 1'b0;
    end else begin
      result_prev_r <= cmp_result;
    end
  end

  assign rise_evt = cmp_result & ~result_prev_r;
  assign fall_evt = ~cmp_result & result_prev_r;
  assign flag_set_evt = cmp_edge_select ? fall_evt : rise_evt;

  // ----------------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------------
  always_comb begin
    evt_now               = '0;
    evt_now[EVT_FLAG_SET] = flag_set_evt;
    evt_now[EVT_RISE]     = rise_evt;
    evt_now[EVT_FALL]     = fall_evt;
  end

  // ----------------------------------------------------------------------
  // Control register one
  // ----------------------------------------------------------------------
  always_comb begin
    ctl_one_nxt = ctl_one_r;
    if (wr_ctl_one) begin
      ctl_one_nxt = wr_byte;
    end
    if (flag_set_evt) begin
      ctl_one_nxt[CTL1_IRQ_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_one_r <= CTL1_RESET;
    end else begin
      ctl_one_r <= ctl_one_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Control register two and buffer disables
  // ----------------------------------------------------------------------
  // Upper bits stored only
  always_comb begin
    ctl_two_nxt = ctl_two_r;
    if (wr_ctl_two) begin
      ctl_two_nxt = {wr_byte[7:1], 1'b0};
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_two_r <= CTL2_RESET;
    end else begin
      ctl_two_r <= ctl_two_nxt;
    end
  end

  always_comb begin
    buf_dis_nxt = buf_dis_r;
    if (wr_buf_dis) begin
      buf_dis_nxt = wr_byte;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      buf_dis_r <= BUF_DIS_RESET;
    end else begin
      buf_dis_r <= buf_dis_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Event status and mask
  // ----------------------------------------------------------------------
  always_comb begin
    evt_status_nxt = evt_status_r;
    if (wr_evt_status) begin
      evt_status_nxt = evt_status_r & ~wr_byte[EVT_W-1:0];
    end
    evt_status_nxt = evt_status_nxt | evt_now;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      evt_status_r <= EVT_RESET;
    end else begin
      evt_status_r <= evt_status_nxt;
    end
  end

  always_comb begin
    evt_mask_nxt = evt_mask_r;
    if (wr_evt_mask) begin
      evt_mask_nxt = wr_byte[EVT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      evt_mask_r <= EVT_RESET;
    end else begin
      evt_mask_r <= evt_mask_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (hit(idx, IDX_CTL_ONE)) begin
      rd_byte = ctl_one_r;
    end else if (hit(idx, IDX_CTL_TWO)) begin
      rd_byte = {ctl_two_r[7:1], cmp_result};
    end else if (hit(idx, IDX_BUF_DIS)) begin
      rd_byte = buf_dis_r;
    end else if (hit(idx, IDX_EVT_STATUS)) begin
      rd_byte = {5'h00, evt_status_r};
    end else if (hit(idx, IDX_EVT_MASK)) begin
      rd_byte = {5'h00, evt_mask_r};
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rd_take ? {24'h000000, rd_byte} : '0;
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdata_r;

  // ----------------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      analog_ctrl_r <= '0;
    end else begin
      analog_ctrl_r.cmp_power_on          <= ctl_one_nxt[CTL1_POWER_ON];
      analog_ctrl_r.reference_select      <=
        reference_select_t'(ctl_one_nxt[CTL1_REF_HI:CTL1_REF_LO]);
      analog_ctrl_r.ref_drive_en          <=
        |ctl_one_nxt[CTL1_REF_HI:CTL1_REF_LO];
      analog_ctrl_r.reference_path_select <= ctl_one_nxt[CTL1_REF_PATH];
      analog_ctrl_r.input_swap            <= ctl_one_nxt[CTL1_SWAP];
      analog_ctrl_r.input_a_connect       <= ctl_two_nxt[CTL2_CONN_A];
      analog_ctrl_r.input_b_connect       <= ctl_two_nxt[CTL2_CONN_B];
      analog_ctrl_r.buffer_disable_bits   <= buf_dis_nxt;
    end
  end

  assign analog_ctrl_out = analog_ctrl_r;

  // ----------------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------------
  // Flag and enable
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp_irq_r <= 1'b0;
    end else begin
      cmp_irq_r <= ctl_one_nxt[CTL1_IRQ_FLAG] & ctl_one_nxt[CTL1_IRQ_ENABLE];
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evt_status_nxt & evt_mask_nxt);
    end
  end

  assign cmp_irq_out = cmp_irq_r;
  assign irq_out     = irq_r;

endmodule : comparator_control_regs

/* hdl/cmp_ctrl_pkg.sv */
// Constants and types shared by the comparator control register block.
package cmp_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register indices and bus geometry
  // ----------------------------------------------------------------------
  localparam int          ADDR_W         = 10;
  localparam int          DATA_W         = 32;
  localparam int          SEL_W          = 4;
  localparam logic [7:0]  IDX_CTL_ONE    = 8'h59;
  localparam logic [7:0]  IDX_CTL_TWO    = 8'h5a;
  localparam logic [7:0]  IDX_BUF_DIS    = 8'h5b;
  localparam logic [7:0]  IDX_EVT_STATUS = 8'h5c;
  localparam logic [7:0]  IDX_EVT_MASK   = 8'h5d;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTL1_IRQ_FLAG   = 0;
  localparam int CTL1_IRQ_ENABLE = 1;
  localparam int CTL1_EDGE_SEL   = 2;
  localparam int CTL1_POWER_ON   = 3;
  localparam int CTL1_REF_LO     = 4;
  localparam int CTL1_REF_HI     = 5;
  localparam int CTL1_REF_PATH   = 6;
  localparam int CTL1_SWAP       = 7;
  localparam int CTL2_RESULT     = 0;
  localparam int CTL2_FILTER     = 1;
  localparam int CTL2_CONN_A     = 2;
  localparam int CTL2_CONN_B     = 3;
  localparam int EVT_FLAG_SET    = 0;
  localparam int EVT_RISE        = 1;
  localparam int EVT_FALL        = 2;
  localparam int EVT_W           = 3;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0]       CTL1_RESET    = 8'h00;
  localparam logic [7:0]       CTL2_RESET    = 8'h00;
  localparam logic [7:0]       BUF_DIS_RESET = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RESET     = 3'h0;
  localparam int               FILTER_LEN    = 3;

  typedef enum logic [1:0] {
    REF_EXTERNAL,
    REF_QUARTER,
    REF_HALF,
    REF_DIODE
  } reference_select_t;

  typedef struct packed {
    logic              cmp_power_on;
    reference_select_t reference_select;
    logic              ref_drive_en;
    logic              reference_path_select;
    logic              input_swap;
    logic              input_a_connect;
    logic              input_b_connect;
    logic [7:0]        buffer_disable_bits;
  } analog_ctrl_t;

endpackage : cmp_ctrl_pkg

/* bench/cmp_core_model.sv */
// Behavioural model of the analog comparator core and its pins.
`timescale 1ns/1ps
module cmp_core_model #(
  parameter int VCC_MV   = 3300,
  parameter int DIODE_MV = 600
) (
  input  cmp_ctrl_pkg::analog_ctrl_t ctrl_in,
  input  int                         a_mv_in,
  input  int                         b_mv_in,
  output logic                       raw_out
);
  import cmp_ctrl_pkg::*;
  int ref_mv;
  int p_mv;
  int m_mv;
  always_comb begin
    case (ctrl_in.reference_select)
      REF_QUARTER: ref_mv = VCC_MV / 4;
      REF_HALF:    ref_mv = VCC_MV / 2;
      REF_DIODE:   ref_mv = DIODE_MV;
      default:     ref_mv = -1;
    endcase
    p_mv = ctrl_in.input_a_connect ? a_mv_in : 0;
    m_mv = ctrl_in.input_b_connect ? b_mv_in : 0;
    if (ctrl_in.ref_drive_en && ctrl_in.reference_path_select) begin
      m_mv = ref_mv;
    end else if (ctrl_in.ref_drive_en) begin
      p_mv = ref_mv;
    end
    raw_out = ctrl_in.cmp_power_on & ((p_mv > m_mv) ^ ctrl_in.input_swap);
  end
endmodule : cmp_core_model

/* bench/comparator_control_regs_checker.sv */
// Concurrent checks on the comparator control block ports.
`timescale 1ns/1ps
module comparator_control_regs_checker #(
  parameter int FILTER_DEPTH = 3
) (
  input logic                            ref_clk_in,
  input logic                            reset_n_in,
  input logic                            wb_cyc_in,
  input logic                            wb_stb_in,
  input logic                            wb_we_in,
  input logic [cmp_ctrl_pkg::ADDR_W-1:0] wb_adr_in,
  input logic [cmp_ctrl_pkg::SEL_W-1:0]  wb_sel_in,
  input logic [cmp_ctrl_pkg::DATA_W-1:0] wb_dat_in,
  input logic [cmp_ctrl_pkg::DATA_W-1:0] wb_dat_out,
  input logic                            wb_ack_out,
  input logic                            cmp_raw_in,
  input cmp_ctrl_pkg::analog_ctrl_t      analog_ctrl_out,
  input logic                            cmp_irq_out,
  input logic                            irq_out
);
  import cmp_ctrl_pkg::*;
  logic req_w;
  logic wr_w;
  assign req_w = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_w  = req_w & wb_we_in & wb_sel_in[0];
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_wr(logic [7:0] idx);
    wr_w && wb_adr_in[9:2] == idx;
  endsequence
  sequence s_off_rd;
    (!analog_ctrl_out.cmp_power_on)[*6] ##0
      (req_w && !wb_we_in && wb_adr_in[9:2] == IDX_CTL_TWO);
  endsequence
  a_ack_after_req: assert property (req_w |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ref_drive_on: assert property (
    analog_ctrl_out.ref_drive_en ==
      (analog_ctrl_out.reference_select != REF_EXTERNAL))
    else $error("reference drive wrong");
  a_ctl_one_fields: assert property (s_wr(IDX_CTL_ONE) |=>
    {analog_ctrl_out.cmp_power_on, analog_ctrl_out.reference_select,
     analog_ctrl_out.reference_path_select, analog_ctrl_out.input_swap}
    == $past({wb_dat_in[3], wb_dat_in[5:4], wb_dat_in[6],
              wb_dat_in[7]}))
    else $error("control one fields wrong");
  a_ctl_two_conn: assert property (s_wr(IDX_CTL_TWO) |=>
    {analog_ctrl_out.input_b_connect, analog_ctrl_out.input_a_connect}
    == $past(wb_dat_in[3:2]))
    else $error("connect bits wrong");
  a_buf_dis_write: assert property (s_wr(IDX_BUF_DIS) |=>
    analog_ctrl_out.buffer_disable_bits == $past(wb_dat_in[7:0]))
    else $error("buffer disable bits wrong");
  a_irq_needs_en: assert property (
    s_wr(IDX_CTL_ONE) ##0 !wb_dat_in[1] |=> !cmp_irq_out)
    else $error("request without enable");
  a_flag_write_set: assert property (
    s_wr(IDX_CTL_ONE) ##0 wb_dat_in[1:0] == 2'h3 |=> cmp_irq_out)
    else $error("written flag gave no request");
  a_mask_zero_quiet: assert property (
    s_wr(IDX_EVT_MASK) ##0 wb_dat_in[2:0] == 3'h0 |=> !irq_out)
    else $error("masked interrupt still high");
  a_off_reads_zero: assert property (s_off_rd |=> !wb_dat_out[0])
    else $error("result high while off");
endmodule : comparator_control_regs_checker
bind comparator_control_regs comparator_control_regs_checker #(
  .FILTER_DEPTH(FILTER_DEPTH)) i_checker (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .cmp_raw_in(cmp_raw_in),
  .analog_ctrl_out(analog_ctrl_out), .cmp_irq_out(cmp_irq_out),
  .irq_out(irq_out));

/* bench/comparator_control_regs_test.sv */
// Self-checking bench for the comparator control register block.
`timescale 1ns/1ps
module comparator_control_regs_test;
  import cmp_ctrl_pkg::*;
  logic              clk   = 1'b0;
  logic              rst_n = 1'b0;
  logic              cyc   = 1'b0;
  logic              stb   = 1'b0;
  logic              we    = 1'b0;
  logic [ADDR_W-1:0] adr   = '0;
  logic [SEL_W-1:0]  sel   = '0;
  logic [DATA_W-1:0] wdat  = '0;
  logic [DATA_W-1:0] rdat;
  logic [DATA_W-1:0] q;
  logic              ack;
  logic              raw;
  logic              cirq;
  logic              irq;
  analog_ctrl_t      actl;
  int                b_mv        = 3000;
  int                n_fail      = 0;
  int                checks_done = 0;
  int                cycles      = 0;
  comparator_control_regs #(.FILTER_DEPTH(3)) i_comparator_control_regs (
    .ref_clk_in(clk), .reset_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .cmp_raw_in(raw),
    .analog_ctrl_out(actl), .cmp_irq_out(cirq), .irq_out(irq));
  cmp_core_model i_cmp_core_model (
    .ctrl_in(actl), .a_mv_in(0), .b_mv_in(b_mv), .raw_out(raw));
  task automatic give_verdict;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= s;
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 4'h1);
  endtask : wr
  task automatic rd_chk(input string n, input logic [7:0] idx,
                        input logic [31:0] e);
    xfer(1'b0, idx, 8'h00, 4'h1);
    check(n, q, e);
  endtask : rd_chk
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("ctl_one", IDX_CTL_ONE, 32'h0);
    rd_chk("ctl_two", IDX_CTL_TWO, 32'h0);
    rd_chk("buf_dis", IDX_BUF_DIS, 32'h0);
    rd_chk("unmapped", 8'h10, 32'h0);
    for (int r = 0; r < 4; r++) begin
      wr(IDX_CTL_ONE, 8'(r << 4));
      check("ref_sel", 32'(actl.reference_select), 32'(r));
      check("ref_drive", 32'(actl.ref_drive_en), 32'(r != 0));
    end
    wr(IDX_CTL_ONE, 8'hc8);
    check("path_swap", 32'({actl.cmp_power_on, actl.reference_path_select,
          actl.input_swap}), 32'h7);
    wr(IDX_CTL_ONE, 8'h48);
    check("path_only", 32'({actl.cmp_power_on, actl.reference_path_select,
          actl.input_swap}), 32'h6);
    wr(IDX_CTL_ONE, 8'h03);
    check("irq_set", 32'(cirq), 32'h1);
    wr(IDX_CTL_TWO, 8'hf5);
    check("conn", 32'({actl.input_b_connect, actl.input_a_connect}),
          32'h1);
    repeat (8) @(posedge clk);
    rd_chk("ctl_two_rb", IDX_CTL_TWO, 32'hf4);
    wr(IDX_BUF_DIS, 8'ha5);
    check("buf_out", 32'(actl.buffer_disable_bits), 32'ha5);
    xfer(1'b1, IDX_BUF_DIS, 8'h00, 4'h0);
    rd_chk("buf_keep", IDX_BUF_DIS, 32'ha5);
    wr(IDX_CTL_TWO, 8'h08);
    wr(IDX_CTL_ONE, 8'h2a);
    repeat (8) @(posedge clk);
    b_mv <= 0;
    repeat (8) @(posedge clk);
    rd_chk("rise_flag", IDX_CTL_ONE, 32'h2b);
    check("cmp_irq", 32'(cirq), 32'h1);
    rd_chk("result", IDX_CTL_TWO, 32'h09);
    wr(IDX_CTL_ONE, 8'h2e);
    check("irq_clr", 32'(cirq), 32'h0);
    b_mv <= 3000;
    repeat (8) @(posedge clk);
    rd_chk("fall_flag", IDX_CTL_ONE, 32'h2f);
    rd_chk("events", IDX_EVT_STATUS, 32'h7);
    wr(IDX_EVT_STATUS, 8'h07);
    wr(IDX_CTL_TWO, 8'h0a);
    repeat (8) @(posedge clk);
    b_mv <= 0;
    @(posedge clk);
    b_mv <= 3000;
    repeat (12) @(posedge clk);
    rd_chk("filtered", IDX_EVT_STATUS, 32'h0);
    wr(IDX_CTL_ONE, 8'h2e);
    wr(IDX_EVT_MASK, 8'h02);
    b_mv <= 0;
    repeat (12) @(posedge clk);
    check("irq_on", 32'(irq), 32'h1);
    rd_chk("rise_ignored", IDX_CTL_ONE, 32'h2e);
    wr(IDX_EVT_MASK, 8'h00);
    check("irq_off", 32'(irq), 32'h0);
    give_verdict();
  end
endmodule : comparator_control_regs_test
